/* logic/adc_seq_pkg.sv */
// constants, register map and field layout for the converter sequencer
package adc_seq_pkg;

   // register port geometry
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // register offsets on the plain register port
   localparam logic [ADDR_W-1:0] OFF_CONV_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] OFF_CONV_CFG = 3'h1;
   localparam logic [ADDR_W-1:0] OFF_GAIN_SENSOR = 3'h2;
   localparam logic [ADDR_W-1:0] OFF_RESULT_HIGH = 3'h3;
   localparam logic [ADDR_W-1:0] OFF_RESULT_LOW = 3'h4;

   // reset value shared by every control register
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

   // conversion control register fields
   localparam int CTRL_START_BIT = 7;
   localparam int CTRL_BUSY_BIT = 6;
   localparam int CTRL_ENABLE_BIT = 5;
   localparam int CTRL_JUSTIFY_BIT = 4;
   localparam int CTRL_CHAN_LSB = 0;
   localparam int CHAN_W = 4;

   // conversion configuration register fields
   localparam int CFG_INSRC_LSB = 5;
   localparam int INSRC_W = 3;
   localparam int CFG_REFSRC_LSB = 3;
   localparam int REFSRC_W = 2;
   localparam int CFG_PRESCALE_LSB = 0;
   localparam int PRESCALE_W = 3;

   // gain and sensor control register fields
   localparam int GAIN_AMP_EN_BIT = 7;
   localparam int GAIN_SEL_LSB = 5;
   localparam int GAIN_SEL_W = 2;
   localparam int GAIN_RESERVED_BIT = 4;
   localparam int GAIN_VSEL_LSB = 2;
   localparam int VSEL_W = 2;
   localparam int GAIN_TRES_BIT = 1;
   localparam int GAIN_TEMP_SENSOR_ENABLE_BIT = 0;

   // gain code that routes the temperature sensor
   localparam logic [GAIN_SEL_W-1:0] GAIN_TEMP_SENSOR = 2'h0;
   // voltage input codes
   localparam logic [VSEL_W-1:0] VSEL_FLOATING = 2'h0;
   localparam logic [VSEL_W-1:0] VSEL_FORBIDDEN = 2'h3;

   // conversion geometry
   localparam int RESULT_W = 12;
   localparam int SAMPLE_PERIODS = 4;
   localparam int CONVERT_PERIODS = 12;
   localparam int PHASE_W = 4;
   localparam int BITIDX_W = 4;
   localparam int DIV_CNT_W = 7;

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT
   } seq_state_e;

endpackage : adc_seq_pkg

/* logic/conv_clock_divider.sv */
// conversion clock divider: power-of-two tick generator
`timescale 1ns/1ps
module conv_clock_divider
   import adc_seq_pkg::*;
#(
   parameter int CODE_W = PRESCALE_W,
   parameter int CNT_W = DIV_CNT_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   input wire logic [CODE_W-1:0] code_i,
   output logic tick_o
);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] limit;

   // code n gives one tick every 2**n system clocks
   assign limit = CNT_W'(({1'b0, CNT_W'(1)} << code_i) - 1'b1);
   assign tick_o = (count == limit) && !restart_i;

   // restart aligns the first period with the start of a conversion
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i || tick_o) begin
         count <= '0;
      end else begin
         count <= count + CNT_W'(1);
      end
   end

endmodule : conv_clock_divider

/* logic/adc_control_sequencer.sv */
// converter control registers and successive-approximation sequencer
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module adc_control_sequencer
   import adc_seq_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // converter core
   input wire logic cmp_i,
   output logic [RESULT_W-1:0] dac_code_o,
   output logic sample_o,
   output logic conv_tick_o,
   output logic converter_power_enable_o,
   output logic [CHAN_W-1:0] channel_select_o,
   output logic [INSRC_W-1:0] input_source_o,
   output logic [REFSRC_W-1:0] ref_source_o,
   // reference amplifier and sensor
   output logic ref_amp_enable_o,
   output logic [GAIN_SEL_W-1:0] ref_amp_gain_select_o,
   output logic sensor_ref_indication_o,
   output logic [VSEL_W-1:0] voltage_input_select_o,
   output logic temp_resolution_option_o,
   output logic temp_sensor_enable_o,
   // status toward the core's interrupt controller
   output logic conv_busy_flag_o,
   output logic conv_done_o
);

   // ------------------------------------------------------------------
   // stored register fields
   // ------------------------------------------------------------------
   logic start_bit;
   logic converter_power_enable;
   logic result_justify_select;
   logic [CHAN_W-1:0] channel_sel;
   logic [DATA_W-1:0] conv_cfg;
   logic [DATA_W-1:0] adc_gain_and_sensor_ctrl;
   logic [RESULT_W-1:0] result;

   // sequencer state
   seq_state_e state;
   logic [PHASE_W-1:0] phase_cnt;
   logic [BITIDX_W-1:0] bit_idx;
   logic [RESULT_W-1:0] sar;
   logic done_pulse;
   logic tick_q;

   // comparator synchroniser; the first stage feeds only the second
   logic cmp_meta;
   logic cmp_sync;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   wire sel_ctrl = (reg_addr_i == OFF_CONV_CTRL);
   wire sel_cfg = (reg_addr_i == OFF_CONV_CFG);
   wire sel_gain = (reg_addr_i == OFF_GAIN_SENSOR);
   wire wr_ctrl = reg_we_i && sel_ctrl;
   wire wr_cfg = reg_we_i && sel_cfg;
   wire wr_gain = reg_we_i && sel_gain;

   // written values of the control fields
   wire wr_start = reg_wdata_i[CTRL_START_BIT];
   wire wr_enable = reg_wdata_i[CTRL_ENABLE_BIT];

   // ------------------------------------------------------------------
   // start detection: a write that drops start from 1 to 0
   // the written enable must also be set, else the pulse is dropped
   // ------------------------------------------------------------------
   wire start_fall = wr_ctrl && start_bit && !wr_start;
   wire launch = start_fall && wr_enable && (state == ST_IDLE);
   // abort on the disabling write itself, so busy never outlives power
   wire power_next = wr_ctrl ? wr_enable : converter_power_enable;

   // decoded configuration fields
   wire [PRESCALE_W-1:0] prescale = conv_cfg[CFG_PRESCALE_LSB +: PRESCALE_W];
   wire [GAIN_SEL_W-1:0] gain_sel = adc_gain_and_sensor_ctrl[GAIN_SEL_LSB +: GAIN_SEL_W];
   wire [VSEL_W-1:0] vsel_raw = adc_gain_and_sensor_ctrl[GAIN_VSEL_LSB +: VSEL_W];

   // ------------------------------------------------------------------
   // conversion clock divider
   // ------------------------------------------------------------------
   logic tick;

   conv_clock_divider #(
      .CODE_W(PRESCALE_W),
      .CNT_W(DIV_CNT_W)
   ) u_divider (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(launch),
      .code_i(prescale),
      .tick_o(tick)
   );

   // ------------------------------------------------------------------
   // successive approximation step values
   // ------------------------------------------------------------------
   wire [RESULT_W-1:0] bit_mask = RESULT_W'(1) << bit_idx;
   wire [RESULT_W-1:0] lower_mask = RESULT_W'(1) << (bit_idx - BITIDX_W'(1));
   // comparator high means input is at or above the trial code
   wire [RESULT_W-1:0] sar_decided = cmp_sync ? sar : (sar & ~bit_mask);
   wire last_bit = (bit_idx == '0);
   wire [RESULT_W-1:0] sar_next = last_bit ? sar_decided : (sar_decided | lower_mask);
   wire last_sample = (phase_cnt == PHASE_W'(SAMPLE_PERIODS - 1));
   wire [RESULT_W-1:0] sar_first = RESULT_W'(1) << (CONVERT_PERIODS - 1);
   wire [BITIDX_W-1:0] first_idx = BITIDX_W'(CONVERT_PERIODS - 1);

   // ------------------------------------------------------------------
   // result formatting, shared by both byte reads
   // ------------------------------------------------------------------
   function automatic logic [2*DATA_W-1:0] justify(input logic [RESULT_W-1:0] r,
                                                   input logic right);
      logic [2*DATA_W-1:0] w;
      w = {{(2*DATA_W-RESULT_W){1'b0}}, r};
      if (right) begin
         justify = w;
      end else begin
         justify = w << (2*DATA_W - RESULT_W);
      end
   endfunction : justify

   wire [2*DATA_W-1:0] result_pair = justify(result, result_justify_select);

   // ------------------------------------------------------------------
   // read mux; unmapped offsets read zero
   // ------------------------------------------------------------------
   wire conv_busy_flag = (state != ST_IDLE);
   wire [DATA_W-1:0] ctrl_view = {start_bit, conv_busy_flag, converter_power_enable,
                                  result_justify_select, channel_sel};
   logic [DATA_W-1:0] read_mux;

   always_comb begin
      if (sel_ctrl) begin
         read_mux = ctrl_view;
      end else if (sel_cfg) begin
         read_mux = conv_cfg;
      end else if (sel_gain) begin
         read_mux = adc_gain_and_sensor_ctrl;
      end else if (reg_addr_i == OFF_RESULT_HIGH) begin
         read_mux = result_pair[2*DATA_W-1:DATA_W];
      end else if (reg_addr_i == OFF_RESULT_LOW) begin
         read_mux = result_pair[DATA_W-1:0];
      end else begin
         read_mux = '0;
      end
   end

   // read data appear only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || !reg_re_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= read_mux;
      end
   end

   // ------------------------------------------------------------------
   // control register writes
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_bit <= REG_RESET[CTRL_START_BIT];
         converter_power_enable <= REG_RESET[CTRL_ENABLE_BIT];
         result_justify_select <= REG_RESET[CTRL_JUSTIFY_BIT];
         channel_sel <= REG_RESET[CTRL_CHAN_LSB +: CHAN_W];
      end else if (wr_ctrl) begin
         start_bit <= wr_start;
         converter_power_enable <= wr_enable;
         result_justify_select <= reg_wdata_i[CTRL_JUSTIFY_BIT];
         channel_sel <= reg_wdata_i[CTRL_CHAN_LSB +: CHAN_W];
      end
   end

   // configuration and gain/sensor registers; reserved bit is stored as written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_cfg <= REG_RESET;
         adc_gain_and_sensor_ctrl <= REG_RESET;
      end else begin
         if (wr_cfg) begin
            conv_cfg <= reg_wdata_i;
         end
         if (wr_gain) begin
            adc_gain_and_sensor_ctrl <= reg_wdata_i;
         end
      end
   end

   // ------------------------------------------------------------------
   // comparator synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
      end else begin
         cmp_meta <= cmp_i;
         cmp_sync <= cmp_meta;
      end
   end

   // ------------------------------------------------------------------
   // sequencer: sample for four periods, then one bit per period
   // disabling the converter aborts and leaves the result alone
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         phase_cnt <= '0;
         bit_idx <= '0;
         sar <= '0;
         result <= '0;
         done_pulse <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (launch) begin
                  state <= ST_SAMPLE;
                  phase_cnt <= '0;
                  bit_idx <= first_idx;
                  sar <= sar_first;
               end
            end
            ST_SAMPLE: begin
               if (!power_next) begin
                  state <= ST_IDLE;
               end else if (tick) begin
                  if (last_sample) begin
                     state <= ST_CONVERT;
                  end
                  phase_cnt <= last_sample ? '0 : phase_cnt + PHASE_W'(1);
               end
            end
            ST_CONVERT: begin
               if (!power_next) begin
                  state <= ST_IDLE;
               end else if (tick) begin
                  sar <= sar_next;
                  bit_idx <= bit_idx - BITIDX_W'(1);
                  if (last_bit) begin
                     state <= ST_IDLE;
                     result <= sar_decided;
                     done_pulse <= 1'b1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // tick is echoed to the core one cycle late, in step with the state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick && conv_busy_flag;
      end
   end

   // ------------------------------------------------------------------
   // outputs toward the analog side and the interrupt controller
   // ------------------------------------------------------------------
   assign converter_power_enable_o = converter_power_enable;
   assign channel_select_o = channel_sel;
   assign input_source_o = conv_cfg[CFG_INSRC_LSB +: INSRC_W];
   assign ref_source_o = conv_cfg[CFG_REFSRC_LSB +: REFSRC_W];
   assign dac_code_o = sar;
   assign sample_o = (state == ST_SAMPLE);
   assign conv_tick_o = tick_q;
   assign conv_busy_flag_o = conv_busy_flag;
   assign conv_done_o = done_pulse;

   // reference amplifier and sensor controls
   assign ref_amp_enable_o = adc_gain_and_sensor_ctrl[GAIN_AMP_EN_BIT];
   assign ref_amp_gain_select_o = gain_sel;
   assign sensor_ref_indication_o = (gain_sel == GAIN_TEMP_SENSOR);
   // the forbidden code is held floating so the analog switch never sees it
   assign voltage_input_select_o = (vsel_raw == VSEL_FORBIDDEN) ? VSEL_FLOATING : vsel_raw;
   assign temp_resolution_option_o = adc_gain_and_sensor_ctrl[GAIN_TRES_BIT];
   assign temp_sensor_enable_o = adc_gain_and_sensor_ctrl[GAIN_TEMP_SENSOR_ENABLE_BIT];

endmodule : adc_control_sequencer

/* dv/adc_seq_properties.sv */
// port-level assertion checker for the converter sequencer
`timescale 1ns/1ps
module adc_seq_checker
   import adc_seq_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic [RESULT_W-1:0] dac_code_o,
   input wire logic sample_o,
   input wire logic converter_power_enable_o,
   input wire logic ref_amp_enable_o,
   input wire logic [GAIN_SEL_W-1:0] ref_amp_gain_select_o,
   input wire logic sensor_ref_indication_o,
   input wire logic [VSEL_W-1:0] voltage_input_select_o,
   input wire logic conv_busy_flag_o,
   input wire logic conv_done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic start_q;
   logic [PRESCALE_W-1:0] pres;
   logic [11:0] busy_n;
   logic [11:0] samp_n;
   // write decode; shadow copies avoid peeking inside the design
   wire ctl_wr = reg_we_i && reg_addr_i == OFF_CONV_CTRL;
   wire cfg_wr = reg_we_i && reg_addr_i == OFF_CONV_CFG;
   wire gain_wr = reg_we_i && reg_addr_i == OFF_GAIN_SENSOR;
   wire en_w = reg_wdata_i[CTRL_ENABLE_BIT];
   wire [2:0] amp_w = reg_wdata_i[7:5];
   wire launch = ctl_wr && start_q && !reg_wdata_i[CTRL_START_BIT] && en_w && !conv_busy_flag_o;
   // shadow start bit, prescale and phase lengths
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_q <= 1'b0;
         pres <= '0;
         busy_n <= '0;
         samp_n <= '0;
      end else begin
         if (ctl_wr) start_q <= reg_wdata_i[CTRL_START_BIT];
         if (cfg_wr) pres <= reg_wdata_i[PRESCALE_W-1:0];
         busy_n <= conv_busy_flag_o ? busy_n + 12'h1 : 12'h0;
         samp_n <= sample_o ? samp_n + 12'h1 : 12'h0;
      end
   end
   start_busy_a: assert property (launch |=> conv_busy_flag_o && sample_o && dac_code_o == 12'h800)
      else $error("start write did not launch a conversion");
   conv_len_a: assert property (conv_done_o |-> !conv_busy_flag_o && busy_n == (12'h10 << pres))
      else $error("conversion length wrong at completion");
   samp_len_a: assert property ($fell(sample_o) && conv_busy_flag_o |-> samp_n == (12'h4 << pres))
      else $error("sampling phase length wrong");
   done_fall_a: assert property ($fell(conv_busy_flag_o) && converter_power_enable_o |-> conv_done_o)
      else $error("completion without done pulse");
   off_idle_a: assert property (!converter_power_enable_o |-> !conv_busy_flag_o)
      else $error("busy while converter is off");
   power_wr_a: assert property (ctl_wr |=> converter_power_enable_o == $past(en_w))
      else $error("power enable does not follow write");
   gain_wr_a: assert property (gain_wr |=> {ref_amp_enable_o, ref_amp_gain_select_o} == $past(amp_w))
      else $error("amplifier fields do not follow write");
   sensor_ind_a: assert property (sensor_ref_indication_o == (ref_amp_gain_select_o == GAIN_TEMP_SENSOR))
      else $error("sensor indication disagrees with gain code");
   vsel_legal_a: assert property (voltage_input_select_o != VSEL_FORBIDDEN)
      else $error("forbidden voltage input code driven");
endmodule : adc_seq_checker
bind adc_control_sequencer adc_seq_checker chk (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
   .reg_we_i, .dac_code_o, .sample_o, .converter_power_enable_o, .ref_amp_enable_o,
   .ref_amp_gain_select_o, .sensor_ref_indication_o, .voltage_input_select_o,
   .conv_busy_flag_o, .conv_done_o);

/* dv/converter_core_model.sv */
// behavioural analog core: track-and-hold plus comparator
`timescale 1ns/1ps
module converter_core_model
   import adc_seq_pkg::*;
(
   input wire logic clk_i,
   input wire logic power_i,
   input wire logic sample_i,
   input wire logic [RESULT_W-1:0] dac_code_i,
   input wire logic [RESULT_W-1:0] level_i,
   output logic cmp_o
);
   logic [RESULT_W-1:0] held;
   logic noise = 1'b0;
   // level frozen once sampling ends
   always_ff @(posedge clk_i) begin
      if (sample_i) held <= level_i;
      noise <= ~noise;
   end
   // unpowered core gives no valid decision, so it toggles
   assign cmp_o = power_i ? (held >= dac_code_i) : noise;
endmodule : converter_core_model

/* dv/adc_control_sequencer_tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adc_control_sequencer_tb_top;
   import adc_seq_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADDR_W-1:0] reg_addr_i = '0;
   logic [DATA_W-1:0] reg_wdata_i = '0;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [DATA_W-1:0] reg_rdata_o;
   logic [RESULT_W-1:0] dac_code_o;
   logic [RESULT_W-1:0] level = '0;
   logic [CHAN_W-1:0] channel_select_o;
   logic [INSRC_W-1:0] input_source_o;
   logic [1:0] ref_source_o, ref_amp_gain_select_o, voltage_input_select_o;
   logic cmp_i, sample_o, conv_tick_o, converter_power_enable_o, ref_amp_enable_o;
   logic sensor_ref_indication_o, temp_resolution_option_o, temp_sensor_enable_o;
   logic conv_busy_flag_o, conv_done_o;
   logic [15:0] done_n = '0;
   logic [15:0] tick_n = '0;
   int n_mismatch = 0;
   int check_count = 0;

   adc_control_sequencer dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
      .reg_re_i, .reg_rdata_o, .cmp_i, .dac_code_o, .sample_o, .conv_tick_o,
      .converter_power_enable_o, .channel_select_o, .input_source_o, .ref_source_o,
      .ref_amp_enable_o, .ref_amp_gain_select_o, .sensor_ref_indication_o,
      .voltage_input_select_o, .temp_resolution_option_o, .temp_sensor_enable_o,
      .conv_busy_flag_o, .conv_done_o);
   converter_core_model core (.clk_i, .power_i(converter_power_enable_o),
      .sample_i(sample_o), .dac_code_i(dac_code_o), .level_i(level), .cmp_o(cmp_i));

   // 100 MHz system clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // count completion pulses and conversion ticks
   always @(posedge clk_i) begin
      if (conv_done_o === 1'b1) done_n <= done_n + 16'h1;
      if (conv_tick_o === 1'b1) tick_n <= tick_n + 16'h1;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rc(input string nm, input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 chk(nm, e, reg_rdata_o);
   endtask : rc
   // full conversion; results unreliable below prescale 2 (sync latency)
   task automatic conv(input logic [2:0] p, input logic j, input logic [11:0] lv);
      int n;
      logic [15:0] d0;
      logic [15:0] t0;
      d0 = done_n;
      t0 = tick_n;
      level <= lv;
      wr(OFF_CONV_CFG, {5'h0, p});
      wr(OFF_CONV_CTRL, {3'h5, j, 4'h0});
      wr(OFF_CONV_CTRL, {3'h1, j, 4'h0});
      #1 n = 0;
      while (conv_busy_flag_o === 1'b1 && n < 3000) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("conv cycles", 16'h10 << p, n[15:0]);
      @(posedge clk_i);
      #1 chk("done pulses", d0 + 16'h1, done_n);
      chk("tick count", t0 + 16'h10, tick_n);
      if (p > 3'h1) begin
         rc("result high", OFF_RESULT_HIGH, j ? {4'h0, lv[11:8]} : lv[11:4]);
         rc("result low", OFF_RESULT_LOW, j ? lv[7:0] : {lv[3:0], 4'h0});
      end
   endtask : conv

   initial begin
      logic [7:0] g8;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      // every offset reads zero after reset
      for (int a = 0; a < 8; a++) begin
         rc("reset value", a[2:0], 8'h00);
      end
      chk("sensor ind reset", 16'h1, sensor_ref_indication_o);
      // every gain and voltage input code; reserved bit kept zero
      for (int g = 0; g < 4; g++) begin
         g8 = {g[0], g[1:0], 1'b0, g[1:0], g[1], ~g[0]};
         wr(OFF_GAIN_SENSOR, g8);
         #1 chk("amp enable", g[0], ref_amp_enable_o);
         chk("gain", g[1:0], ref_amp_gain_select_o);
         chk("sensor ind", g == 0, sensor_ref_indication_o);
         chk("vsel", (g == 3) ? 2'h0 : g[1:0], voltage_input_select_o);
         chk("tres temp_sensor_enable", {g[1], ~g[0]}, {temp_resolution_option_o, temp_sensor_enable_o});
         if (g != 3) rc("gain readback", OFF_GAIN_SENSOR, g8);
      end
      wr(OFF_CONV_CFG, 8'hab);
      #1 chk("input src", 3'h5, input_source_o);
      chk("ref src", 2'h1, ref_source_o);
      rc("cfg readback", OFF_CONV_CFG, 8'hab);
      wr(OFF_CONV_CTRL, 8'h1c);
      #1 chk("channel", 4'hc, channel_select_o);
      rc("ctrl readback", OFF_CONV_CTRL, 8'h1c);
      wr(3'h5, 8'hff);
      rc("unmapped", 3'h5, 8'h00);
      wr(OFF_RESULT_HIGH, 8'hff);
      rc("result ro", OFF_RESULT_HIGH, 8'h00);
      // start pulse with the converter off
      wr(OFF_CONV_CTRL, 8'h80);
      wr(OFF_CONV_CTRL, 8'h00);
      #1 chk("busy off start", 16'h0, conv_busy_flag_o);
      // every prescale code, both justifications
      for (int p = 0; p < 8; p++) begin
         conv(p[2:0], p[0], 12'ha5c ^ {p[2:0], 9'h0});
      end
      conv(3'h2, 1'b0, 12'h3c7);
      // abort during the sampling phase keeps the old result
      wr(OFF_CONV_CTRL, 8'ha0);
      wr(OFF_CONV_CTRL, 8'h20);
      rc("busy bit", OFF_CONV_CTRL, 8'h60);
      g8 = done_n[7:0];
      wr(OFF_CONV_CTRL, 8'h00);
      #1 chk("abort busy", 16'h0, conv_busy_flag_o);
      chk("power off", 16'h0, converter_power_enable_o);
      repeat (80) @(posedge clk_i);
      #1 chk("abort no done", g8, done_n);
      rc("kept high", OFF_RESULT_HIGH, 8'h3c);
      rc("kept low", OFF_RESULT_LOW, 8'h70);
      results();
   end
   // watchdog well beyond the expected run of about 4.4k cycles
   initial begin
      #500000;
      n_mismatch++;
      results();
   end
endmodule : adc_control_sequencer_tb_top
